// ---- hdl/adccfg_cfg.svh ----
// Overview of operation
// R1 - Eight-bit channel register, one enable per input
// R2 - Bits 3..0 enable inputs 3..0, reset zero
// R3 - New selection applies after one more conversion
// R4 - New selection restarts at lowest enabled input
// R5 - Sixteen-bit readable writable mode register
// R6 - Bit 15 picks open-drain or push-pull flag
// R7 - Bit 14 drives third general output level
// R8 - Bit 11 low filters 50 ns bus spikes
// R9 - Bits 10 and 8 decode conversion mode
// R10 - Bit 9 resets control, result, alert state
// R11 - Soft reset bit clears on next cycle
// R12 - Bits 7:6 pick 100..800 us autocycle interval
// R13 - Bit 4 gives flag pin alert/busy duty
// R14 - Bit 5 shows busy; reads zero otherwise
// R15 - Serial slave never stretches clock nor general-calls
`ifndef ADCCFG_CFG_SVH
`define ADCCFG_CFG_SVH

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define ADCCFG_ADDR_CHANNEL 8'h01
`define ADCCFG_ADDR_SETUP 8'h02
`define ADCCFG_CHANNEL_RESET 8'h00
`define ADCCFG_SETUP_RESET 16'h00C0
`define ADCCFG_CHANNEL_WMASK 8'h0F
`define ADCCFG_SETUP_WMASK 16'hCDFF

// ----------------------------------------
// Field positions of the setup register
// ----------------------------------------
`define ADCCFG_BIT_DRIVE 15
`define ADCCFG_BIT_GENERAL_OUTPUT_THIRD_LEVEL 14
`define ADCCFG_BIT_FILTER 11
`define ADCCFG_BIT_CMD 10
`define ADCCFG_BIT_SOFT_RESET_TRIGGER 9
`define ADCCFG_BIT_AUTO 8
`define ADCCFG_TIMER_HI 7
`define ADCCFG_TIMER_LO 6
`define ADCCFG_BIT_BUSY 5
`define ADCCFG_BIT_FLAGEN 4
`define ADCCFG_BIT_POL 3
`define ADCCFG_BIT_GENERAL_OUTPUT_SECOND_LEVEL 2
`define ADCCFG_PDOWN_HI 1
`define ADCCFG_PDOWN_LO 0

// ----------------------------------------
// Timing
// ----------------------------------------
`define ADCCFG_CLK_PERIOD_NS 8
`define ADCCFG_SPIKE_NS 50
`define ADCCFG_SPIKE_CYCLES ((`ADCCFG_SPIKE_NS + `ADCCFG_CLK_PERIOD_NS - 1) / `ADCCFG_CLK_PERIOD_NS)
`define ADCCFG_TIMER_BASE_NS 100000
`define ADCCFG_TIMER_BASE_CYCLES (`ADCCFG_TIMER_BASE_NS / `ADCCFG_CLK_PERIOD_NS)

`endif

// ---- hdl/adccfg_pkg.sv ----
package adccfg_pkg;

    // ----------------------------------------
    // Register port request
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } adccfg_req_t;

    // ----------------------------------------
    // Register port answer
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic [15:0] rdata;
    } adccfg_rsp_t;

    // ----------------------------------------
    // Two-way pin drive
    // ----------------------------------------
    typedef struct packed {
        logic out;
        logic oe;
    } adccfg_pin_t;

    // ----------------------------------------
    // Conversion modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        ADCCFG_MODE_SAMPLE = 2'h0,
        ADCCFG_MODE_COMMAND = 2'h1,
        ADCCFG_MODE_AUTO = 2'h2
    } adccfg_mode_t;

    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        ADCCFG_SEQ_IDLE = 2'b01,
        ADCCFG_SEQ_BUSY = 2'b10
    } adccfg_seq_t;

endpackage

// ---- hdl/adccfg_spike_filter.sv ----
`timescale 1ns/1ns
`include "adccfg_cfg.svh"

module adccfg_spike_filter #(
    parameter int STABLE_CYCLES = `ADCCFG_SPIKE_CYCLES,
    parameter int CW = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Control
    input wire logic bypass,
    // Line
    input wire logic pinIn,
    output logic filtOut
);

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (STABLE_CYCLES < 1 || STABLE_CYCLES >= (1 << CW)) begin : gBadParam
        $error("adccfg_spike_filter: STABLE_CYCLES does not fit CW");
    end

    localparam logic [CW-1:0] LIMIT = CW'(STABLE_CYCLES);

    logic sync1_q, sync2_q;
    logic [CW-1:0] cnt_q, cnt_d;
    logic out_q, out_d;

    // ----------------------------------------
    // Filter
    // ----------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        out_d = out_q;
        if (bypass) begin
            cnt_d = '0;
            out_d = sync2_q;
        end else if (sync2_q == out_q) begin
            cnt_d = '0;
        end else if (cnt_q + CW'(1) >= LIMIT) begin
            cnt_d = '0;
            out_d = sync2_q;
        end else begin
            cnt_d = cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            cnt_q <= '0;
            out_q <= 1'b1;
        end else if (ce) begin
            sync1_q <= pinIn;
            sync2_q <= sync1_q;
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign filtOut = out_q;

endmodule

// ---- hdl/adccfg_top.sv ----
`timescale 1ns/1ns
`include "adccfg_cfg.svh"

module adccfg_top
    import adccfg_pkg::*;
#(
    parameter int TIMER_BASE_CYCLES = `ADCCFG_TIMER_BASE_CYCLES,
    parameter int TW = 20
) (
    // Clock, enable and reset
    input wire logic clock,
    input wire logic ce,
    input wire logic rst_n,
    // Register port from serial slave
    input wire adccfg_req_t regReq,
    output adccfg_rsp_t regRsp,
    // Serial bus lines, raw and filtered
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclFilt,
    output logic sdaFilt,
    // Converter handshake
    input wire logic cmdConvReq,
    input wire logic convDone,
    input wire logic alertIn,
    output logic convStart,
    output logic [1:0] convChannel,
    output logic convBusy,
    output adccfg_mode_t convMode,
    output logic [1:0] powerMode,
    output logic softResetPulse,
    // Pins
    input wire logic convertTriggerIn,
    output adccfg_pin_t convertTriggerPin,
    output adccfg_pin_t flagPin,
    output logic generalOutputThirdLevel
);

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (TIMER_BASE_CYCLES < 1 || (TIMER_BASE_CYCLES * 8) >= (1 << TW)) begin : gBadParam
        $error("adccfg_top: TIMER_BASE_CYCLES does not fit TW");
    end

    localparam logic [TW-1:0] BASE = TW'(TIMER_BASE_CYCLES);

    // ----------------------------------------
    // Next enabled input after cur, wrapping
    // ----------------------------------------
    function automatic logic [1:0] nextInput(input logic [3:0] mask, input logic [1:0] cur);
        logic [1:0] pick;
        logic [1:0] idx;
        logic found;
        pick = cur;
        found = 1'b0;
        for (int i = 1; i <= 4; i++) begin
            idx = cur + 2'(i);
            if (!found && mask[idx]) begin
                pick = idx;
                found = 1'b1;
            end
        end
        return pick;
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] channel_q, channel_d;
    logic [15:0] setup_q, setup_d;
    logic soft_reset_trigger_q, soft_reset_trigger_d;
    adccfg_rsp_t rsp_q, rsp_d;
    logic wrChannel, wrSetup;
    logic [15:0] setupRead;

    assign wrChannel = regReq.wr && (regReq.addr == `ADCCFG_ADDR_CHANNEL);
    assign wrSetup = regReq.wr && (regReq.addr == `ADCCFG_ADDR_SETUP);

    always_comb begin
        setupRead = setup_q & `ADCCFG_SETUP_WMASK;
        setupRead[`ADCCFG_BIT_SOFT_RESET_TRIGGER] = soft_reset_trigger_q;
        // R14 busy reads zero
        if (!setup_q[`ADCCFG_BIT_FLAGEN]) begin
            setupRead[`ADCCFG_BIT_BUSY] = 1'b0;
        end
    end

    always_comb begin
        channel_d = channel_q;
        setup_d = setup_q;
        rsp_d = '0;
        // R1 R2 channel enables
        if (wrChannel) begin
            channel_d = regReq.wdata[7:0] & `ADCCFG_CHANNEL_WMASK;
        end
        // R5 setup register write
        if (wrSetup) begin
            setup_d = regReq.wdata & `ADCCFG_SETUP_WMASK;
        end
        // R11 self-clearing reset bit
        soft_reset_trigger_d = wrSetup && regReq.wdata[`ADCCFG_BIT_SOFT_RESET_TRIGGER];
        if (regReq.rd) begin
            rsp_d.valid = 1'b1;
            case (regReq.addr)
                `ADCCFG_ADDR_CHANNEL: rsp_d.rdata = {8'h00, channel_q};
                `ADCCFG_ADDR_SETUP: rsp_d.rdata = setupRead;
                default: rsp_d.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            channel_q <= `ADCCFG_CHANNEL_RESET;
            setup_q <= `ADCCFG_SETUP_RESET;
            soft_reset_trigger_q <= 1'b0;
            rsp_q <= '0;
        end else if (ce) begin
            channel_q <= channel_d;
            setup_q <= setup_d;
            soft_reset_trigger_q <= soft_reset_trigger_d;
            rsp_q <= rsp_d;
        end
    end

    assign regRsp = rsp_q;
    // R10 reset pulse to result and alert
    assign softResetPulse = soft_reset_trigger_q;
    assign powerMode = setup_q[`ADCCFG_PDOWN_HI:`ADCCFG_PDOWN_LO];
    // R7 third output level
    assign generalOutputThirdLevel = setup_q[`ADCCFG_BIT_GENERAL_OUTPUT_THIRD_LEVEL];

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    adccfg_mode_t mode;

    always_comb begin
        // R9 command and autocycle decode
        case ({setup_q[`ADCCFG_BIT_CMD], setup_q[`ADCCFG_BIT_AUTO]})
            2'b10: mode = ADCCFG_MODE_COMMAND;
            2'b01: mode = ADCCFG_MODE_AUTO;
            default: mode = ADCCFG_MODE_SAMPLE;
        endcase
    end

    assign convMode = mode;

    // ----------------------------------------
    // Bus line spike filters
    // ----------------------------------------
    // R8 spike filter bypass
    adccfg_spike_filter #(
        .STABLE_CYCLES(`ADCCFG_SPIKE_CYCLES),
        .CW(4)
    ) uSclFilter (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .bypass(setup_q[`ADCCFG_BIT_FILTER]),
        .pinIn(sclIn),
        .filtOut(sclFilt)
    );

    adccfg_spike_filter #(
        .STABLE_CYCLES(`ADCCFG_SPIKE_CYCLES),
        .CW(4)
    ) uSdaFilter (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .bypass(setup_q[`ADCCFG_BIT_FILTER]),
        .pinIn(sdaIn),
        .filtOut(sdaFilt)
    );

    // ----------------------------------------
    // Trigger pin synchroniser
    // ----------------------------------------
    logic trig1_q, trig2_q, trig3_q;
    logic trigFall;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            trig1_q <= 1'b1;
            trig2_q <= 1'b1;
            trig3_q <= 1'b1;
        end else if (ce) begin
            trig1_q <= convertTriggerIn;
            trig2_q <= trig1_q;
            trig3_q <= trig2_q;
        end
    end

    assign trigFall = trig3_q && !trig2_q;

    // ----------------------------------------
    // Autocycle timer
    // ----------------------------------------
    logic [TW-1:0] tmr_q, tmr_d;
    logic [TW-1:0] interval;
    logic tmrExpire;

    // R12 interval select
    assign interval = BASE << setup_q[`ADCCFG_TIMER_HI:`ADCCFG_TIMER_LO];
    assign tmrExpire = (mode == ADCCFG_MODE_AUTO) && (tmr_q == interval - TW'(1));

    always_comb begin
        tmr_d = tmr_q + TW'(1);
        // R10 timer reset
        if (soft_reset_trigger_q || mode != ADCCFG_MODE_AUTO || tmrExpire) begin
            tmr_d = '0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tmr_q <= '0;
        end else if (ce) begin
            tmr_q <= tmr_d;
        end
    end

    // ----------------------------------------
    // Channel sequencer
    // ----------------------------------------
    adccfg_seq_t state_q, state_d;
    logic [3:0] active_q, active_d;
    logic [3:0] pend_q, pend_d;
    logic pendValid_q, pendValid_d;
    logic [1:0] cur_q, cur_d;
    logic start_q, start_d;
    logic [1:0] chan_q, chan_d;
    logic startReq;

    always_comb begin
        case (mode)
            ADCCFG_MODE_AUTO: startReq = tmrExpire;
            ADCCFG_MODE_COMMAND: startReq = cmdConvReq;
            default: startReq = trigFall;
        endcase
    end

    always_comb begin
        state_d = state_q;
        active_d = active_q;
        pend_d = pend_q;
        pendValid_d = pendValid_q;
        cur_d = cur_q;
        start_d = 1'b0;
        chan_d = chan_q;
        case (state_q)
            ADCCFG_SEQ_IDLE: begin
                if (startReq) begin
                    start_d = 1'b1;
                    chan_d = cur_q;
                    state_d = ADCCFG_SEQ_BUSY;
                end
            end
            ADCCFG_SEQ_BUSY: begin
                if (convDone) begin
                    state_d = ADCCFG_SEQ_IDLE;
                    // R3 apply after one conversion
                    if (pendValid_q) begin
                        active_d = pend_q;
                        pendValid_d = 1'b0;
                        // R4 restart at lowest input
                        cur_d = nextInput(pend_q, 2'h3);
                    end else begin
                        cur_d = nextInput(active_q, cur_q);
                    end
                end
            end
            default: state_d = ADCCFG_SEQ_IDLE;
        endcase
        // R3 hold new selection pending
        if (wrChannel) begin
            pend_d = regReq.wdata[3:0];
            pendValid_d = 1'b1;
        end
        // R10 control logic reset
        if (soft_reset_trigger_q) begin
            state_d = ADCCFG_SEQ_IDLE;
            start_d = 1'b0;
            cur_d = nextInput(active_q, 2'h3);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ADCCFG_SEQ_IDLE;
            active_q <= 4'h0;
            pend_q <= 4'h0;
            pendValid_q <= 1'b0;
            cur_q <= 2'h0;
            start_q <= 1'b0;
            chan_q <= 2'h0;
        end else if (ce) begin
            state_q <= state_d;
            active_q <= active_d;
            pend_q <= pend_d;
            pendValid_q <= pendValid_d;
            cur_q <= cur_d;
            start_q <= start_d;
            chan_q <= chan_d;
        end
    end

    assign convStart = start_q;
    assign convChannel = chan_q;
    assign convBusy = (state_q == ADCCFG_SEQ_BUSY);

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    adccfg_pin_t flag_q, flag_d;
    adccfg_pin_t trigPin_q, trigPin_d;
    logic flagLevel;
    logic flagActive;

    always_comb begin
        // R14 busy or alert source
        flagActive = setup_q[`ADCCFG_BIT_BUSY] ? convBusy : alertIn;
        // R13 flag or general output
        if (setup_q[`ADCCFG_BIT_FLAGEN]) begin
            flagLevel = setup_q[`ADCCFG_BIT_POL] ? flagActive : !flagActive;
        end else begin
            flagLevel = setup_q[`ADCCFG_BIT_POL];
        end
        // R6 open-drain or push-pull
        if (setup_q[`ADCCFG_BIT_DRIVE]) begin
            flag_d.out = flagLevel;
            flag_d.oe = 1'b1;
        end else begin
            flag_d.out = 1'b0;
            flag_d.oe = !flagLevel;
        end
        // Trigger pin is an input in sample mode
        trigPin_d.out = setup_q[`ADCCFG_BIT_GENERAL_OUTPUT_SECOND_LEVEL];
        trigPin_d.oe = (mode != ADCCFG_MODE_SAMPLE);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= '0;
            trigPin_q <= '0;
        end else if (ce) begin
            flag_q <= flag_d;
            trigPin_q <= trigPin_d;
        end
    end

    assign flagPin = flag_q;
    assign convertTriggerPin = trigPin_q;

    // R15 bus clock only observed, never held
    // (no drive toward the clock line exists here)

endmodule

// ---- test/adc_channel_and_mode_config_bench.sv ----
`timescale 1ns/1ns
module adc_channel_and_mode_config_bench;
    import adccfg_pkg::*;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic cmdConvReq = 1'h0;
    logic convDone = 1'h0;
    logic alertIn = 1'h0;
    logic sdaIn = 1'h1;
    adccfg_req_t regReq;
    adccfg_rsp_t regRsp;
    adccfg_mode_t convMode;
    adccfg_pin_t flagPin, convertTriggerPin;
    logic [1:0] convChannel, powerMode;
    logic trigIn = 1'h1;
    logic sclFilt, sdaFilt, convStart, convBusy, softResetPulse, generalOutputThirdLevel;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int doneDelay = 6;
    int doneLeft = 0;
    always #4 clock = ~clock;
    adccfg_top #(.TIMER_BASE_CYCLES(4)) i_dut (.clock, .ce(1'h1), .rst_n, .regReq, .regRsp,
        .sclIn(sdaIn), .sdaIn, .sclFilt, .sdaFilt, .cmdConvReq, .convDone, .alertIn,
        .convStart, .convChannel, .convBusy, .convMode, .powerMode, .softResetPulse,
        .convertTriggerIn(trigIn), .convertTriggerPin, .flagPin, .generalOutputThirdLevel);
    adccfg_host_model i_host (.clock, .regReq, .regRsp);
    // Converter answers after doneDelay cycles
    always @(negedge clock) begin
        convDone = (doneLeft == 1);
        if (convStart) begin
            doneLeft = doneDelay;
        end else if (softResetPulse) begin
            doneLeft = 0;
        end else if (doneLeft > 0) begin
            doneLeft--;
        end
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (fail_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        i_host.access(1'h1, a, d, q);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] q;
        i_host.access(1'h0, a, 16'h0000, q);
        chk(nm, q, exp);
    endtask
    task automatic conv(input logic [1:0] ch, input logic [7:0] newSel);
        @(negedge clock) cmdConvReq = 1'h1;
        @(negedge clock) cmdConvReq = 1'h0;
        chk("start", convStart, 1'h1);
        chk("channel", convChannel, ch);
        if (newSel != 8'h00) begin
            wr(8'h01, {8'h00, newSel});
        end
        repeat (20) if (convBusy) cyc(1);
    endtask
    task automatic t_regs();
        rdchk("chan", 8'h01, 16'h0000);
        rdchk("setup", 8'h02, 16'h00C0);
        rdchk("unmapped", 8'h03, 16'h0000);
        wr(8'h01, 16'hFFFF);
        rdchk("chan", 8'h01, 16'h000F);
        wr(8'h02, 16'hFDFF);
        rdchk("setup", 8'h02, 16'hCDFF);
        chk("gpo3", generalOutputThirdLevel, 1'h1);
        chk("power", powerMode, 2'h3);
        chk("trig pin", convertTriggerPin, 2'h2);
        wr(8'h02, 16'h0020);
        rdchk("busy bit", 8'h02, 16'h0000);
    endtask
    task automatic t_seq();
        wr(8'h02, 16'h8438);
        wr(8'h01, 16'h000A);
        chk("trig pin", convertTriggerPin, 2'h1);
        conv(2'h0, 8'h00);
        conv(2'h1, 8'h00);
        conv(2'h3, 8'h00);
        conv(2'h1, 8'h0C);
        conv(2'h2, 8'h00);
        conv(2'h3, 8'h00);
    endtask
    task automatic t_soft();
        @(negedge clock) cmdConvReq = 1'h1;
        @(negedge clock) cmdConvReq = 1'h0;
        wr(8'h02, 16'h0600);
        chk("soft_reset_trigger pulse", softResetPulse, 1'h1);
        cyc(1);
        chk("soft_reset_trigger end", softResetPulse, 1'h0);
        chk("idle", convBusy, 1'h0);
        rdchk("setup", 8'h02, 16'h0400);
        rdchk("chan", 8'h01, 16'h000C);
        conv(2'h2, 8'h00);
    endtask
    task automatic t_modes();
        adccfg_mode_t m [4] = '{ADCCFG_MODE_SAMPLE, ADCCFG_MODE_AUTO, ADCCFG_MODE_COMMAND,
            ADCCFG_MODE_SAMPLE};
        for (int i = 0; i < 4; i++) begin
            wr(8'h02, {5'h00, i[1], 1'h0, i[0], 8'h00});
            chk("mode", convMode, m[i]);
        end
    endtask
    task automatic t_auto();
        int n;
        doneDelay = 1;
        for (int k = 0; k < 4; k++) begin
            wr(8'h02, 16'h0000);
            cyc(3);
            wr(8'h02, {8'h01, k[1:0], 6'h00});
            n = 0;
            while (!convStart && n < 80) begin
                cyc(1);
                n++;
            end
            chk("auto gap", n >= (4 << k) - 1 && n <= (4 << k) + 2, 1'h1);
        end
    endtask
    task automatic t_trig();
        wr(8'h02, 16'h0000);
        trigIn = 1'h0;
        cyc(3);
        chk("trig start", convStart, 1'h1);
        trigIn = 1'h1;
        cyc(3);
    endtask
    task automatic t_flag();
        logic [18:0] tab [7] = '{{1'h1, 16'h8018, 2'h3}, {1'h0, 16'h8018, 2'h1},
            {1'h1, 16'h0018, 2'h0}, {1'h1, 16'h0010, 2'h1}, {1'h0, 16'h0008, 2'h0},
            {1'h0, 16'h8000, 2'h1}, {1'h0, 16'h8008, 2'h3}};
        for (int i = 0; i < 7; i++) begin
            alertIn = tab[i][18];
            wr(8'h02, tab[i][17:2]);
            cyc(2);
            chk("flag", flagPin, tab[i][1:0]);
        end
    endtask
    task automatic spike(input logic [15:0] s, input int w, input logic exp);
        logic seen;
        logic seenScl;
        seen = 1'h0;
        seenScl = 1'h0;
        wr(8'h02, s);
        cyc(10);
        chk("sda idle", sdaFilt, 1'h1);
        sdaIn = 1'h0;
        for (int i = 0; i < 16; i++) begin
            cyc(1);
            sdaIn = (i >= w);
            seen |= !sdaFilt;
            seenScl |= !sclFilt;
        end
        chk("sda filter", seen, exp);
        chk("scl filter", seenScl, exp);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        @(negedge clock) rst_n = 1'h1;
        t_regs();
        t_seq();
        t_soft();
        t_modes();
        t_auto();
        t_trig();
        t_flag();
        spike(16'h0000, 3, 1'h0);
        spike(16'h0000, 10, 1'h1);
        spike(16'h0800, 3, 1'h1);
        report_and_stop();
    end
endmodule
bind adccfg_top adccfg_checker i_chk (.clock, .rst_n, .ce, .regReq, .regRsp, .cmdConvReq,
    .convStart, .convBusy, .convMode, .softResetPulse, .flagPin, .generalOutputThirdLevel);

// ---- test/adccfg_checker_asserts.sv ----
`timescale 1ns/1ns
`include "adccfg_cfg.svh"
module adccfg_checker
    import adccfg_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Register port
    input wire adccfg_req_t regReq,
    input wire adccfg_rsp_t regRsp,
    // Converter
    input wire logic cmdConvReq,
    input wire logic convStart,
    input wire logic convBusy,
    input wire adccfg_mode_t convMode,
    input wire logic softResetPulse,
    // Pins
    input wire adccfg_pin_t flagPin,
    input wire logic generalOutputThirdLevel
);
    logic [15:0] setup_q;
    logic [15:0] setup_d;
    logic setupWr;
    // ----
    // Setup shadow
    // ----
    assign setupWr = ce && regReq.wr && regReq.addr == `ADCCFG_ADDR_SETUP;
    always_comb begin
        setup_d = setup_q;
        if (setupWr) begin
            setup_d = regReq.wdata & `ADCCFG_SETUP_WMASK;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            setup_q <= `ADCCFG_SETUP_RESET;
        end else begin
            setup_q <= setup_d;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_soft_reset_trigger_wr;
        setupWr && regReq.wdata[9];
    endsequence
    sequence s_pulse_once;
        softResetPulse ##1 !softResetPulse;
    endsequence
    property p_rd_ans;
        ce && regReq.rd |=> regRsp.valid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
    property p_soft_reset_trigger;
        s_soft_reset_trigger_wr |=> s_pulse_once;
    endproperty
    a_soft_reset_trigger: assert property (p_soft_reset_trigger) else $error("soft reset pulse wrong");
    property p_soft_reset_trigger_idle;
        softResetPulse |-> ##[0:1] !convBusy;
    endproperty
    a_soft_reset_trigger_idle: assert property (p_soft_reset_trigger_idle) else $error("busy after soft reset");
    property p_mode;
        convMode == (setup_q[10] ^ setup_q[8] ? (setup_q[10] ? ADCCFG_MODE_COMMAND :
            ADCCFG_MODE_AUTO) : ADCCFG_MODE_SAMPLE);
    endproperty
    a_mode: assert property (p_mode) else $error("mode decode wrong");
    property p_gpo3;
        generalOutputThirdLevel == setup_q[14];
    endproperty
    a_gpo3: assert property (p_gpo3) else $error("third output wrong");
    property p_drive;
        $stable(setup_q) |-> (setup_q[15] ? flagPin.oe : !flagPin.out);
    endproperty
    a_drive: assert property (p_drive) else $error("flag drive type wrong");
    property p_flag_gpo;
        !setup_q[4] && !setup_q[15] ##1 $stable(setup_q) |-> flagPin.oe == !setup_q[3];
    endproperty
    a_flag_gpo: assert property (p_flag_gpo) else $error("flag level wrong");
    property p_flag_busy;
        setup_q[15] && setup_q[5:3] == 3'h7 ##1 $stable(setup_q) |->
            flagPin.out == $past(convBusy);
    endproperty
    a_flag_busy: assert property (p_flag_busy) else $error("flag busy wrong");
    property p_cmd_start;
        convMode == ADCCFG_MODE_COMMAND && ce && cmdConvReq && !convBusy && !softResetPulse
            |=> convStart;
    endproperty
    a_cmd_start: assert property (p_cmd_start) else $error("command start missing");
endmodule

// ---- test/adccfg_host_model.sv ----
`timescale 1ns/1ns
module adccfg_host_model
    import adccfg_pkg::*;
(
    // Clock
    input wire logic clock,
    // Register port
    output adccfg_req_t regReq,
    input wire adccfg_rsp_t regRsp
);
    initial begin
        regReq = '0;
    end
    task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d,
        output logic [15:0] q);
        @(negedge clock);
        regReq = {w, !w, a, d};
        @(negedge clock);
        q = regRsp.valid ? regRsp.rdata : 16'hDEAD;
        regReq = {2'h0, ~a, ~d};
    endtask
endmodule
